// File: core/i2c_irq_regs.vh
`ifndef I2C_IRQ_REGS_VH
`define I2C_IRQ_REGS_VH

// register byte addresses on the local register port
`define ADDR_STATUS 8'h20
`define ADDR_IRQ_ENABLE_SET 8'h24
`define ADDR_IRQ_ENABLE_CLEAR 8'h28
`define ADDR_IRQ_ENABLE_VIEW 8'h2c
`define ADDR_RX_BYTE_HOLD 8'h30
`define ADDR_TX_BYTE_HOLD 8'h34
`define ADDR_STATUS_CLEAR 8'h38

// shared layout of status, enable and mask words
`define FLAG_WIDTH 9
`define BIT_TRANSFER_DONE 0
`define BIT_RX_BYTE_READY 1
`define BIT_TX_HOLD_FREE 2
`define BIT_RX_OVERRUN 6
`define BIT_TX_UNDERRUN 7
`define BIT_NO_ACK 8

// bits of the layout that exist; all others reserved
`define FLAG_USED_MASK 9'h1c7

// status bits that the clear register may drop
`define FLAG_SW_CLEARABLE 9'h1c1

// reset values
`define RESET_MASK 9'h000
`define RESET_BYTE 8'h00
`define RESET_WORD 32'h0000_0000

// byte width of the holding registers
`define BYTE_WIDTH 8

`endif

// File: core/event_flag.v
`default_nettype none

// one sticky status bit; a set in the same cycle as a clear wins
module event_flag (
   input wire ref_clk,
   input wire rst,
   input wire set,
   input wire clr,
   output reg q
);

   // next value of the flag
   wire q_next;

   // set dominates, otherwise hold unless cleared
   assign q_next = set | (q & ~clr);

   // synchronous update
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         q <= 1'b0;
      end
      else
      begin
         q <= q_next;
      end
   end

endmodule

`default_nettype wire

// File: core/byte_hold.v
`default_nettype none

// byte wide holding register with a load strobe
module byte_hold #(
   parameter WIDTH = 8
) (
   input wire ref_clk,
   input wire rst,
   input wire load,
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);

   // keep the byte until the next load
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         dout <= {WIDTH{1'b0}};
      end
      else if (load)
      begin
         dout <= din;
      end
   end

endmodule

`default_nettype wire

// File: core/i2c_irq_mask_and_holding_regs.v
// Chosen here: the placing of the registers and the address-and-strobe port.
`include "i2c_irq_regs.vh"
`default_nettype none

module i2c_irq_mask_and_holding_regs (
   input wire ref_clk,
   input wire rstn,
   input wire soft_reset,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire [7:0] rx_byte_in,
   input wire rx_byte_load,
   input wire tx_shift_load,
   output wire [7:0] tx_byte_out,
   output reg tx_byte_valid,
   input wire frame_done_evt,
   input wire no_ack_flag_evt,
   input wire master_enable_evt,
   output reg irq_out
);

   // combined reset: pin or software reset
   wire rst;

   // register port decode strobes
   wire wr_enable_set;
   wire wr_enable_clear;
   wire wr_tx_hold;
   wire wr_status_clear;
   wire rd_rx_hold;
   wire rd_status;

   // interrupt mask, one means source enabled
   reg [`FLAG_WIDTH-1:0] mask_reg;
   reg [`FLAG_WIDTH-1:0] mask_next;

   // write data cut to the flag layout
   wire [`FLAG_WIDTH-1:0] wdata_flags;

   // sticky status flags and their set / clear terms
   wire [`FLAG_WIDTH-1:0] status_flags;
   reg [`FLAG_WIDTH-1:0] flag_set;
   reg [`FLAG_WIDTH-1:0] flag_clr;

   // received byte as held for software
   wire [`BYTE_WIDTH-1:0] rx_byte_field;

   // transmit hold occupancy next value
   reg tx_valid_next;

   // read data mux output
   reg [31:0] rdata_next;

   // single named flags for readability
   wire transfer_done_flag;
   wire rx_byte_ready_flag;
   wire tx_hold_free_flag;
   wire rx_overrun_flag;
   wire tx_underrun_flag;
   wire no_ack_flag;

   // loop index for the flag cells
   genvar gi;

   // defined positions of the layout, one bit per cell
   wire [`FLAG_WIDTH-1:0] used_bits;

   // interrupt level before its output flip-flop
   reg irq_next;

   // software reset acts as a system reset
   assign rst = ~rstn | soft_reset;

   // reserved positions get no set term at their cell
   assign used_bits = `FLAG_USED_MASK;

   // address decode, one strobe at a time from the master
   assign wr_enable_set = reg_wr & (reg_addr == `ADDR_IRQ_ENABLE_SET);
   assign wr_enable_clear = reg_wr & (reg_addr == `ADDR_IRQ_ENABLE_CLEAR);
   assign wr_tx_hold = reg_wr & (reg_addr == `ADDR_TX_BYTE_HOLD);
   assign wr_status_clear = reg_wr & (reg_addr == `ADDR_STATUS_CLEAR);
   assign rd_rx_hold = reg_rd & (reg_addr == `ADDR_RX_BYTE_HOLD);
   assign rd_status = reg_rd & (reg_addr == `ADDR_STATUS);

   // only the defined bit positions can ever reach the mask
   assign wdata_flags = reg_wdata[`FLAG_WIDTH-1:0] & `FLAG_USED_MASK;

   // named views of the status vector
   assign transfer_done_flag = status_flags[`BIT_TRANSFER_DONE];
   assign rx_byte_ready_flag = status_flags[`BIT_RX_BYTE_READY];
   assign tx_hold_free_flag = status_flags[`BIT_TX_HOLD_FREE];
   assign rx_overrun_flag = status_flags[`BIT_RX_OVERRUN];
   assign tx_underrun_flag = status_flags[`BIT_TX_UNDERRUN];
   assign no_ack_flag = status_flags[`BIT_NO_ACK];

   // mask update: ones set or clear, zeros leave bits alone
   always @*
   begin
      mask_next = mask_reg;
      if (wr_enable_set)
      begin
         // set only where the written word carries ones
         mask_next = mask_reg | wdata_flags;
      end
      else if (wr_enable_clear)
      begin
         // clear only where the written word carries ones
         mask_next = mask_reg & ~wdata_flags;
      end
   end

   // mask register
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         mask_reg <= `RESET_MASK;
      end
      else
      begin
         mask_reg <= mask_next;
      end
   end

   // hardware set terms for each status source
   always @*
   begin
      flag_set = {`FLAG_WIDTH{1'b0}};
      // frame finished, or master just enabled
      flag_set[`BIT_TRANSFER_DONE] = frame_done_evt | master_enable_evt;
      // a byte landed in the receive hold
      flag_set[`BIT_RX_BYTE_READY] = rx_byte_load;
      // byte moved into the shifter, a no_ack_flag, or master enabled
      flag_set[`BIT_TX_HOLD_FREE] = (tx_shift_load & tx_byte_valid) |
         no_ack_flag_evt | master_enable_evt;
      // new byte while the previous one was still unread
      flag_set[`BIT_RX_OVERRUN] = rx_byte_load & rx_byte_ready_flag;
      // shifter wanted a byte but the hold was empty
      flag_set[`BIT_TX_UNDERRUN] = tx_shift_load & ~tx_byte_valid;
      // far end did not acknowledge
      flag_set[`BIT_NO_ACK] = no_ack_flag_evt;
   end

   // clear terms: reads, writes and the clear register
   always @*
   begin
      flag_clr = {`FLAG_WIDTH{1'b0}};
      if (wr_status_clear)
      begin
         // software drop of the error and completion bits
         flag_clr = wdata_flags & `FLAG_SW_CLEARABLE;
      end
      if (rd_rx_hold)
      begin
         // reading the received byte frees the hold
         flag_clr[`BIT_RX_BYTE_READY] = 1'b1;
      end
      if (wr_tx_hold)
      begin
         // a fresh byte occupies the transmit hold
         flag_clr[`BIT_TX_HOLD_FREE] = 1'b1;
      end
      if (rd_status)
      begin
         // no_ack_flag is cleared by reading the status word
         flag_clr[`BIT_NO_ACK] = 1'b1;
         if (transfer_done_flag)
         begin
            // error bits drop on a status read once done
            flag_clr[`BIT_RX_OVERRUN] = 1'b1;
            flag_clr[`BIT_TX_UNDERRUN] = 1'b1;
         end
      end
   end

   // one sticky cell per layout position, reserved ones never set
   generate
      for (gi = 0; gi < `FLAG_WIDTH; gi = gi + 1)
      begin : flag_cells
         event_flag u_flag (
            .ref_clk(ref_clk),
            .rst(rst),
            .set(flag_set[gi] & used_bits[gi]),
            .clr(flag_clr[gi]),
            .q(status_flags[gi])
         );
      end
   endgenerate

   // limitation: a write in the same cycle as a shifter take
   // leaves the hold full, yet the take's set wins over the
   // write's clear, so the free flag reads one; software
   // should write the hold only while the flag shows free

   // receive holding register, loaded by the receive path
   byte_hold #(
      .WIDTH(`BYTE_WIDTH)
   ) u_rx_hold (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(rx_byte_load),
      .din(rx_byte_in),
      .dout(rx_byte_field)
   );

   // transmit holding register, loaded by software
   byte_hold #(
      .WIDTH(`BYTE_WIDTH)
   ) u_tx_hold (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(wr_tx_hold),
      .din(reg_wdata[`BYTE_WIDTH-1:0]),
      .dout(tx_byte_out)
   );

   // transmit hold occupancy
   always @*
   begin
      tx_valid_next = tx_byte_valid;
      if (wr_tx_hold)
      begin
         // new byte wins over a same-cycle take
         tx_valid_next = 1'b1;
      end
      else if (tx_shift_load)
      begin
         // shifter took the byte, hold now empty
         tx_valid_next = 1'b0;
      end
   end

   // occupancy register, drives the shifter side
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         tx_byte_valid <= 1'b0;
      end
      else
      begin
         tx_byte_valid <= tx_valid_next;
      end
   end

   // read data selection, unmapped and write-only read as zero
   always @*
   begin
      rdata_next = `RESET_WORD;
      case (reg_addr)
         `ADDR_STATUS:
         begin
            // live status flags
            rdata_next[`FLAG_WIDTH-1:0] = status_flags & `FLAG_USED_MASK;
         end
         `ADDR_IRQ_ENABLE_VIEW:
         begin
            // current mask, one means enabled
            rdata_next[`FLAG_WIDTH-1:0] = mask_reg;
         end
         `ADDR_RX_BYTE_HOLD:
         begin
            // last received byte, upper bits zero
            rdata_next[`BYTE_WIDTH-1:0] = rx_byte_field;
         end
         `ADDR_TX_BYTE_HOLD:
         begin
            // byte waiting for the shifter
            rdata_next[`BYTE_WIDTH-1:0] = tx_byte_out;
         end
         default:
         begin
            // write-only, unmapped: zero
            rdata_next = `RESET_WORD;
         end
      endcase
   end

   // read data stands only in the cycle after the read strobe
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         reg_rdata <= `RESET_WORD;
      end
      else if (reg_rd)
      begin
         reg_rdata <= rdata_next;
      end
      else
      begin
         reg_rdata <= `RESET_WORD;
      end
   end

   // any enabled source raises the interrupt level
   always @*
   begin
      irq_next = 1'b0;
      if (transfer_done_flag & mask_reg[`BIT_TRANSFER_DONE])
      begin
         irq_next = 1'b1;
      end
      if (rx_byte_ready_flag & mask_reg[`BIT_RX_BYTE_READY])
      begin
         irq_next = 1'b1;
      end
      if (tx_hold_free_flag & mask_reg[`BIT_TX_HOLD_FREE])
      begin
         irq_next = 1'b1;
      end
      if (rx_overrun_flag & mask_reg[`BIT_RX_OVERRUN])
      begin
         irq_next = 1'b1;
      end
      if (tx_underrun_flag & mask_reg[`BIT_TX_UNDERRUN])
      begin
         irq_next = 1'b1;
      end
      if (no_ack_flag & mask_reg[`BIT_NO_ACK])
      begin
         irq_next = 1'b1;
      end
   end

   // interrupt level from enabled status bits
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         irq_out <= 1'b0;
      end
      else
      begin
         irq_out <= irq_next;
      end
   end

endmodule

`default_nettype wire

// File: testbench/i2c_irq_props.sv
`include "i2c_irq_regs.vh"
`default_nettype none
// checks on register port and byte paths
module i2c_irq_props (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic soft_reset,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_byte_load,
   input wire logic tx_shift_load,
   input wire logic [7:0] tx_byte_out,
   input wire logic tx_byte_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn || soft_reset);
   // strobe decodes
   wire logic rd_vw = reg_rd && reg_addr == `ADDR_IRQ_ENABLE_VIEW;
   wire logic rd_rx = reg_rd && reg_addr == `ADDR_RX_BYTE_HOLD;
   wire logic wr_tx = reg_wr && reg_addr == `ADDR_TX_BYTE_HOLD;
   wire logic wr_set = reg_wr && reg_addr == `ADDR_IRQ_ENABLE_SET;
   wire logic wr_clr = reg_wr && reg_addr == `ADDR_IRQ_ENABLE_CLEAR;
   wire logic [7:0] wbyte = reg_wdata[7:0]; // low byte of a write
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 0)
      else $error("read data not idle");
   a_rx_upper: assert property (rd_rx |=> reg_rdata[31:8] == 0)
      else $error("rx hold upper bits set");
   a_view_layout: assert property
      (rd_vw |=> (reg_rdata & ~32'h0000_01c7) == 0)
      else $error("reserved mask bit set");
   a_set_mask: assert property (wr_set ##1 !reg_wr ##1 rd_vw |=>
      (reg_rdata & $past(reg_wdata, 3) & 32'h0000_01c7)
      == ($past(reg_wdata, 3) & 32'h0000_01c7))
      else $error("set write missed a mask bit");
   a_clr_mask: assert property (wr_clr ##1 !reg_wr ##1 rd_vw |=>
      (reg_rdata & $past(reg_wdata, 3)) == 0)
      else $error("clear write left a mask bit");
   a_tx_load: assert property (wr_tx |=>
      tx_byte_valid && tx_byte_out == $past(wbyte))
      else $error("tx hold not loaded");
   a_tx_take: assert property
      (tx_shift_load && !wr_tx |=> !tx_byte_valid)
      else $error("tx hold still full after take");
   a_tx_keep: assert property
      (tx_byte_valid && !tx_shift_load && !wr_tx |=>
      tx_byte_valid && $stable(tx_byte_out))
      else $error("tx hold lost its byte");
   a_rx_read: assert property (rx_byte_load ##1 !rx_byte_load ##1
      (rd_rx && !rx_byte_load) |=> reg_rdata == {24'h0, $past(rx_byte_in, 3)})
      else $error("rx hold byte wrong");
   // main scenarios reached
   c_set_view: cover property (wr_set ##2 rd_vw);
   c_rx_read: cover property (rx_byte_load ##2 rd_rx);
   c_tx_take: cover property (tx_byte_valid ##1 !tx_byte_valid);
endmodule
bind i2c_irq_mask_and_holding_regs i2c_irq_props props (
   .ref_clk(ref_clk), .rstn(rstn), .soft_reset(soft_reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_byte_in(rx_byte_in),
   .rx_byte_load(rx_byte_load), .tx_shift_load(tx_shift_load),
   .tx_byte_out(tx_byte_out), .tx_byte_valid(tx_byte_valid));
`default_nettype wire

// File: testbench/test_i2c_irq_mask_and_holding_regs.sv
`include "i2c_irq_regs.vh"
`default_nettype none
// register port bench for the mask and holding block
module test_i2c_irq_mask_and_holding_regs;
   timeunit 1ns;
   timeprecision 1ps;
   // short address names
   localparam logic [7:0] st_a = `ADDR_STATUS;
   localparam logic [7:0] set_a = `ADDR_IRQ_ENABLE_SET;
   localparam logic [7:0] clr_a = `ADDR_IRQ_ENABLE_CLEAR;
   localparam logic [7:0] vw_a = `ADDR_IRQ_ENABLE_VIEW;
   localparam logic [7:0] rx_a = `ADDR_RX_BYTE_HOLD;
   localparam logic [7:0] tx_a = `ADDR_TX_BYTE_HOLD;
   localparam logic [7:0] sc_a = `ADDR_STATUS_CLEAR;
   logic ref_clk = 0, rstn = 0, soft_reset = 0, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 0, rx_byte_in = 0, tx_byte_out;
   logic [31:0] reg_wdata = 0, reg_rdata;
   logic [4:0] ev_bus = 0; // rx load, take, done, no ack, enable
   logic tx_byte_valid, irq_out;
   int err_count = 0, checks = 0;
   i2c_irq_mask_and_holding_regs dut (.ref_clk(ref_clk), .rstn(rstn),
      .soft_reset(soft_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rx_byte_in(rx_byte_in), .rx_byte_load(ev_bus[4]),
      .tx_shift_load(ev_bus[3]), .tx_byte_out(tx_byte_out),
      .tx_byte_valid(tx_byte_valid), .frame_done_evt(ev_bus[2]),
      .no_ack_flag_evt(ev_bus[1]), .master_enable_evt(ev_bus[0]),
      .irq_out(irq_out));
   // 100 MHz clock
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   // compare and count
   task check(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // one write cycle
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 0;
   endtask
   // one read cycle, data looked at in the cycle after
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 0;
      @(negedge ref_clk);
      check(reg_rdata, e);
   endtask
   // one-cycle event pulses
   task ev(input logic [4:0] e, input logic [7:0] b);
      @(posedge ref_clk);
      ev_bus <= e;
      rx_byte_in <= b;
      @(posedge ref_clk);
      ev_bus <= 0;
   endtask
   // interrupt lags status by a cycle
   task irq_is(input logic e);
      @(negedge ref_clk);
      @(negedge ref_clk);
      check(irq_out, e);
   endtask
   // counts and verdict
   task give_verdict;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      err_count++;
      give_verdict;
   end
   // test sequence
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1;
      rd(vw_a, 0);
      rd(rx_a, 0);
      rd(tx_a, 0);
      rd(st_a, 0);
      rd(8'h3c, 0);
      rd(set_a, 0);
      $display("test reset done");
      wr(set_a, 32'hffff_ffff);
      rd(vw_a, 9'h1c7);
      wr(clr_a, 9'h101);
      rd(vw_a, 9'h0c6);
      wr(set_a, 9'h000);
      wr(vw_a, 9'h000);
      rd(vw_a, 9'h0c6);
      wr(set_a, 9'h001);
      rd(vw_a, 9'h0c7);
      wr(clr_a, 32'hffff_ffff);
      rd(vw_a, 9'h000);
      $display("test mask done");
      ev(5'h10, 8'ha5);
      rd(st_a, 9'h002);
      rd(rx_a, 8'ha5);
      rd(st_a, 9'h000);
      ev(5'h10, 8'h3c);
      ev(5'h10, 8'h5a);
      rd(st_a, 9'h042);
      rd(rx_a, 8'h5a);
      wr(sc_a, 9'h040);
      rd(st_a, 9'h000);
      ev(5'h10, 8'hc3);
      rd(rx_a, 8'hc3);
      rd(st_a, 9'h000);
      $display("test receive done");
      ev(5'h01, 8'h00);
      rd(st_a, 9'h005);
      wr(tx_a, 32'h1234_5678);
      rd(tx_a, 8'h78);
      rd(st_a, 9'h001);
      check(tx_byte_out, 8'h78);
      ev(5'h08, 8'h00);
      rd(st_a, 9'h005);
      ev(5'h08, 8'h00);
      rd(st_a, 9'h085);
      rd(st_a, 9'h005);
      $display("test transmit done");
      wr(set_a, 9'h004);
      irq_is(1);
      wr(clr_a, 9'h004);
      irq_is(0);
      wr(set_a, 9'h100);
      ev(5'h02, 8'h00);
      irq_is(1);
      rd(st_a, 9'h105);
      irq_is(0);
      wr(sc_a, 9'h001);
      wr(set_a, 9'h001);
      irq_is(0);
      ev(5'h04, 8'h00);
      irq_is(1);
      $display("test interrupt done");
      @(posedge ref_clk);
      soft_reset <= 1;
      @(posedge ref_clk);
      soft_reset <= 0;
      rd(vw_a, 9'h000);
      irq_is(0);
      $display("test soft reset done");
      give_verdict;
   end
endmodule
`default_nettype wire
